/* File: rtl/lps_led_pwm.v */
// Purpose: LED PWM source selection, dimming rate, brightness scale, engine execution state
// Assumes: Byte register port from a serial bus slave, synchronous to sys_clk
// Notes:   Engine instruction decode lives elsewhere; engines signal completion here
//
// Notes on behaviour
// - Map register picks each LED source, 00 direct
// - Codes 01,10,11 route engines one to three
// - Direct duty writes take effect immediately
// - LED current outputs fixed at 17.5mA default code, not register mapped
// - Config bit 6 selects 256 or 558 Hz
// - Enable bit 7 selects linear or log scale
// - Config bit 0 selects internal timing clock
// - Blue, green, red duties at 02h-04h
// - Three engines with mode, state, counter
// - Execution fields at bits 5:4, 3:2, 1:0
// - Hold stops after instruction; counter host access then
// - Step executes, increments counter, returns to hold
// - Run executes continuously from current counter
// - Execute-one runs one instruction, returns hold
// - Direct engine mode uses blue/green/red duty
// - White direct duty sits at 0Eh
`default_nettype none
`include "lps_map.vh"

module lps_led_pwm #(
   parameter NUM_ENG = 3,
   parameter NUM_LED = 4
) (
   input  wire                 sys_clk,
   input  wire                 arst_n,
   input  wire                 reg_wr,
   input  wire                 reg_rd,
   input  wire [7:0]           reg_addr,
   input  wire [7:0]           reg_wdata,
   output reg  [7:0]           reg_rdata,
   input  wire [NUM_ENG*8-1:0] engine_duty,
   input  wire [NUM_ENG-1:0]   engine_instr_done,
   output wire [NUM_ENG-1:0]   engine_execute,
   output wire [NUM_ENG-1:0]   engine_pc_advance,
   output wire [NUM_ENG*4-1:0] engine_pc,
   output wire [NUM_ENG*2-1:0] engine_mode,
   output wire                 internal_clock_select,
   output wire                 chip_on,
   output wire [NUM_LED*8-1:0] led_current,
   output wire [NUM_LED-1:0]   led_pwm
);

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   reg  [7:0]           engine_exec_and_scale_ctrl;
   reg  [7:0]           op_mode;
   reg  [7:0]           blue_direct_duty;
   reg  [7:0]           green_direct_duty;
   reg  [7:0]           red_direct_duty;
   reg  [7:0]           white_direct_duty;
   reg  [7:0]           clock_and_rate_config;
   reg  [7:0]           output_source_map;
   reg  [NUM_ENG*4-1:0] pc;
   reg  [NUM_ENG-1:0]   busy;
   reg  [NUM_ENG-1:0]   step_inc;

   wire dimming_rate_select = clock_and_rate_config[`LPS_BIT_RATE_HF];
   wire log_scale           = engine_exec_and_scale_ctrl[`LPS_BIT_LOG_EN];

   assign internal_clock_select = clock_and_rate_config[`LPS_BIT_INT_CLK];
   assign chip_on               = engine_exec_and_scale_ctrl[`LPS_BIT_CHIP_EN];
   assign engine_mode           = op_mode[NUM_ENG*2-1:0];
   assign engine_pc             = pc;
   assign led_current           = {NUM_LED{`LPS_RST_CURRENT}};

   // Engine k execution field: engine 1 at 5:4 down to engine 3 at 1:0
   function [1:0] exec_field;
      input [7:0] ctrl;
      input integer k;
      begin
         exec_field = ctrl[(NUM_ENG-1-k)*2 +: 2];
      end
   endfunction

   function [1:0] mode_field;
      input [7:0] m;
      input integer k;
      begin
         mode_field = m[(NUM_ENG-1-k)*2 +: 2];
      end
   endfunction

   // Counter register offset of engine k
   function [7:0] pc_ofs;
      input integer k;
      begin
         pc_ofs = `LPS_OFS_PC1 + k[7:0];
      end
   endfunction

   // ---------------------------------------------------------------
   // Engine execution control
   // ---------------------------------------------------------------
   reg [7:0] next_ctrl;
   integer   e;
   always @* begin
      next_ctrl = engine_exec_and_scale_ctrl;
      if (reg_wr && reg_addr == `LPS_OFS_EXEC_SCALE) begin
         next_ctrl = reg_wdata;
      end
      for (e = 0; e < NUM_ENG; e = e + 1) begin
         if (busy[e] && engine_instr_done[e] &&
             (exec_field(engine_exec_and_scale_ctrl, e) == `LPS_EXEC_STEP ||
              exec_field(engine_exec_and_scale_ctrl, e) == `LPS_EXEC_ONE)) begin
            next_ctrl[(NUM_ENG-1-e)*2 +: 2] = `LPS_EXEC_HOLD;
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < NUM_ENG; g = g + 1) begin : g_eng
         wire [1:0] st  = exec_field(engine_exec_and_scale_ctrl, g);
         wire [1:0] md  = mode_field(op_mode, g);
         wire       act = (md == `LPS_MODE_RUN) && (st != `LPS_EXEC_HOLD);
         // Busy covers the instruction in flight, so hold lets it finish
         assign engine_execute[g]    = act || busy[g];
         assign engine_pc_advance[g] = busy[g] && engine_instr_done[g] &&
                                       (step_inc[g] || st == `LPS_EXEC_RUN);

         always @(posedge sys_clk or negedge arst_n) begin
            if (!arst_n) begin
               busy[g]        <= 1'b0;
               step_inc[g]    <= 1'b0;
               pc[g*4 +: 4]   <= 4'h0;
            end else begin
               if (busy[g] && engine_instr_done[g]) begin
                  busy[g] <= act && st == `LPS_EXEC_RUN;
               end else if (!busy[g] && act) begin
                  busy[g]     <= 1'b1;
                  step_inc[g] <= (st == `LPS_EXEC_STEP);
               end
               if (md != `LPS_MODE_RUN) begin
                  pc[g*4 +: 4] <= 4'h0;
               end else if (engine_pc_advance[g]) begin
                  pc[g*4 +: 4] <= pc[g*4 +: 4] + 4'h1;
               end else if (reg_wr && st == `LPS_EXEC_HOLD && !busy[g] &&
                            reg_addr == pc_ofs(g)) begin
                  pc[g*4 +: 4] <= reg_wdata[3:0];
               end
            end
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // Register writes
   // ---------------------------------------------------------------
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         engine_exec_and_scale_ctrl <= `LPS_RST_REG;
         op_mode                    <= `LPS_RST_REG;
         blue_direct_duty           <= `LPS_RST_REG;
         green_direct_duty          <= `LPS_RST_REG;
         red_direct_duty            <= `LPS_RST_REG;
         white_direct_duty          <= `LPS_RST_REG;
         clock_and_rate_config      <= `LPS_RST_REG;
         output_source_map          <= `LPS_RST_REG;
      end else begin
         engine_exec_and_scale_ctrl <= next_ctrl;
         if (reg_wr) begin
            case (reg_addr)
               `LPS_OFS_OP_MODE:    op_mode               <= {2'h0, reg_wdata[5:0]};
               `LPS_OFS_BLUE_DUTY:  blue_direct_duty      <= reg_wdata;
               `LPS_OFS_GREEN_DUTY: green_direct_duty     <= reg_wdata;
               `LPS_OFS_RED_DUTY:   red_direct_duty       <= reg_wdata;
               `LPS_OFS_WHITE_DUTY: white_direct_duty     <= reg_wdata;
               `LPS_OFS_CLK_CFG:    clock_and_rate_config <= reg_wdata;
               `LPS_OFS_SRC_MAP:    output_source_map     <= reg_wdata;
               default: ;
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // Register reads
   // ---------------------------------------------------------------
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            `LPS_OFS_EXEC_SCALE: reg_rdata <= engine_exec_and_scale_ctrl;
            `LPS_OFS_OP_MODE:    reg_rdata <= op_mode;
            `LPS_OFS_BLUE_DUTY:  reg_rdata <= blue_direct_duty;
            `LPS_OFS_GREEN_DUTY: reg_rdata <= green_direct_duty;
            `LPS_OFS_RED_DUTY:   reg_rdata <= red_direct_duty;
            `LPS_OFS_WHITE_DUTY: reg_rdata <= white_direct_duty;
            `LPS_OFS_CLK_CFG:    reg_rdata <= clock_and_rate_config;
            `LPS_OFS_PC1:        reg_rdata <= {4'h0, pc[3:0]};
            `LPS_OFS_PC2:        reg_rdata <= {4'h0, pc[7:4]};
            `LPS_OFS_PC3:        reg_rdata <= {4'h0, pc[11:8]};
            `LPS_OFS_SRC_MAP:    reg_rdata <= output_source_map;
            default:             reg_rdata <= 8'h00;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // PWM frame timing
   // ---------------------------------------------------------------
   localparam integer SLOT_LO_N = `LPS_SLOT_LO_CYC;
   localparam integer SLOT_HI_N = `LPS_SLOT_HI_CYC;
   localparam [11:0]  SLOT_LO   = SLOT_LO_N[11:0];
   localparam [11:0]  SLOT_HI   = SLOT_HI_N[11:0];

   reg  [11:0] slot_count;
   reg  [7:0]  frame_count;
   wire [11:0] slot_len = dimming_rate_select ? SLOT_HI : SLOT_LO;

   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         slot_count  <= 12'h000;
         frame_count <= 8'h00;
      end else if (slot_count >= slot_len - 12'h001) begin
         slot_count  <= 12'h000;
         frame_count <= frame_count + 8'h01;
      end else begin
         slot_count  <= slot_count + 12'h001;
      end
   end

   // ---------------------------------------------------------------
   // Engine duty and source selection
   // ---------------------------------------------------------------
   wire [7:0] direct_duty [0:3];
   assign direct_duty[0] = blue_direct_duty;
   assign direct_duty[1] = green_direct_duty;
   assign direct_duty[2] = red_direct_duty;
   assign direct_duty[3] = white_direct_duty;

   wire [7:0] eng_duty [0:NUM_ENG-1];
   generate
      for (g = 0; g < NUM_ENG; g = g + 1) begin : g_eduty
         wire [1:0] md = mode_field(op_mode, g);
         assign eng_duty[g] = (md == `LPS_MODE_DIRECT) ? direct_duty[g] :
                              (md == `LPS_MODE_RUN)    ? engine_duty[g*8 +: 8] :
                              8'h00;
      end
   endgenerate

   generate
      for (g = 0; g < NUM_LED; g = g + 1) begin : g_led
         wire [1:0] sel = output_source_map[g*2 +: 2];
         reg  [7:0] led_duty;
         always @* begin
            case (sel)
               2'h0:    led_duty = direct_duty[g];
               2'h1:    led_duty = eng_duty[0];
               2'h2:    led_duty = eng_duty[1];
               default: led_duty = eng_duty[2];
            endcase
         end
         lps_pwm_channel #(
            .WIDTH (8)
         ) u_chan (
            .sys_clk     (sys_clk),
            .arst_n      (arst_n),
            .duty        (led_duty),
            .log_scale   (log_scale),
            .frame_count (frame_count),
            .pwm_out     (led_pwm[g])
         );
      end
   endgenerate

endmodule // lps_led_pwm

`default_nettype wire

/* File: rtl/lps_map.vh */
// Purpose: Register offsets, field positions, reset values and timing for the LED PWM block
// Assumes: Byte-wide register port, 100 MHz sys_clk
// Notes:   Definitions only
`ifndef LPS_MAP_VH
`define LPS_MAP_VH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define LPS_OFS_EXEC_SCALE   8'h00
`define LPS_OFS_OP_MODE      8'h01
`define LPS_OFS_BLUE_DUTY    8'h02
`define LPS_OFS_GREEN_DUTY   8'h03
`define LPS_OFS_RED_DUTY     8'h04
`define LPS_OFS_CLK_CFG      8'h08
`define LPS_OFS_PC1          8'h09
`define LPS_OFS_PC2          8'h0A
`define LPS_OFS_PC3          8'h0B
`define LPS_OFS_WHITE_DUTY   8'h0E
`define LPS_OFS_SRC_MAP      8'h70

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define LPS_BIT_LOG_EN       7
`define LPS_BIT_CHIP_EN      6
`define LPS_BIT_RATE_HF      6
`define LPS_BIT_INT_CLK      0

// ---------------------------------------------------------------
// Codes and reset values
// ---------------------------------------------------------------
`define LPS_EXEC_HOLD        2'h0
`define LPS_EXEC_STEP        2'h1
`define LPS_EXEC_RUN         2'h2
`define LPS_EXEC_ONE         2'h3
`define LPS_MODE_DISABLED    2'h0
`define LPS_MODE_LOAD        2'h1
`define LPS_MODE_RUN         2'h2
`define LPS_MODE_DIRECT      2'h3
`define LPS_RST_REG          8'h00
`define LPS_RST_CURRENT      8'hAF

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define LPS_CLK_HZ           100000000
`define LPS_RATE_LO_HZ       256
`define LPS_RATE_HI_HZ       558
`define LPS_SLOT_LO_CYC      (`LPS_CLK_HZ / (`LPS_RATE_LO_HZ * 256))
`define LPS_SLOT_HI_CYC      (`LPS_CLK_HZ / (`LPS_RATE_HI_HZ * 256))
`define LPS_INSTR_CYC        16'h0BEB

`endif

/* File: rtl/lps_pwm_channel.v */
// Purpose: One PWM output: compares a scaled duty against a shared frame counter
// Assumes: Frame counter runs 0..255 each PWM period
// Notes:   Log curve is a fixed square law: upper byte of duty squared, except duty FF maps to FF
`default_nettype none

module lps_pwm_channel #(
   parameter WIDTH = 8
) (
   input  wire             sys_clk,
   input  wire             arst_n,
   input  wire [WIDTH-1:0] duty,
   input  wire             log_scale,
   input  wire [WIDTH-1:0] frame_count,
   output reg              pwm_out
);

   // ---------------------------------------------------------------
   // Duty mapping
   // ---------------------------------------------------------------
   wire [2*WIDTH-1:0] duty_sq;
   wire [WIDTH-1:0]   log_duty;
   wire [WIDTH-1:0]   eff_duty;

   assign duty_sq  = {{WIDTH{1'b0}}, duty} * {{WIDTH{1'b0}}, duty};
   assign log_duty = (duty == {WIDTH{1'b1}}) ? {WIDTH{1'b1}} :
                     duty_sq[2*WIDTH-1:WIDTH];
   assign eff_duty = log_scale ? log_duty : duty;

   // ---------------------------------------------------------------
   // Comparator
   // ---------------------------------------------------------------
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         pwm_out <= 1'b0;
      end else if (eff_duty == {WIDTH{1'b1}}) begin
         pwm_out <= 1'b1;
      end else begin
         pwm_out <= (frame_count < eff_duty);
      end
   end

endmodule // lps_pwm_channel

`default_nettype wire

/* File: verification/lps_led_pwm_props.sv */
// Purpose: Port-level checks of the LED PWM block
// Assumes: Engine 1 slices stand for all three engines
// Notes:   Bound into every lps_led_pwm instance
`default_nettype none
module lps_led_pwm_props #(
   parameter NUM_ENG = 3,
   parameter NUM_LED = 4
) (
   input wire logic                 sys_clk,
   input wire logic                 arst_n,
   input wire logic                 reg_wr,
   input wire logic                 reg_rd,
   input wire logic [7:0]           reg_addr,
   input wire logic [7:0]           reg_wdata,
   input wire logic [7:0]           reg_rdata,
   input wire logic [NUM_ENG-1:0]   engine_instr_done,
   input wire logic [NUM_ENG-1:0]   engine_execute,
   input wire logic [NUM_ENG-1:0]   engine_pc_advance,
   input wire logic [NUM_ENG*4-1:0] engine_pc,
   input wire logic [NUM_ENG*2-1:0] engine_mode,
   input wire logic                 internal_clock_select,
   input wire logic [NUM_LED*8-1:0] led_current
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   chk_current_def: assert property (led_current == {NUM_LED{8'hAF}})
      else $error("LED current differs from default");
   chk_unmapped_rd: assert property (reg_rd && reg_addr == 8'h7F |=> reg_rdata == 8'h00)
      else $error("Unmapped read not zero");
   chk_blue_rdback: assert property ((reg_wr && reg_addr == 8'h02) ##2
      (reg_rd && reg_addr == 8'h02) |=> reg_rdata == $past(reg_wdata, 3))
      else $error("Blue duty read back wrong");
   chk_clk_select: assert property (reg_wr && reg_addr == 8'h08
      |=> internal_clock_select == $past(reg_wdata[0]))
      else $error("Clock select not taken");
   chk_mode_write: assert property (reg_wr && reg_addr == 8'h01
      |=> engine_mode == $past(reg_wdata[NUM_ENG*2-1:0]))
      else $error("Mode write not taken");
   chk_run_start: assert property (reg_wr && reg_addr == 8'h00 && reg_wdata[5:4] == 2'h2
      && engine_mode[5:4] == 2'h2 && !engine_execute[0] |=> engine_execute[0])
      else $error("Run did not start");
   chk_adv_on_done: assert property (engine_pc_advance[0] |-> engine_instr_done[0])
      else $error("Counter advanced without done");
   chk_adv_incr: assert property (engine_pc_advance[0]
      |=> engine_pc[3:0] == $past(engine_pc[3:0]) + 4'h1)
      else $error("Counter did not step by one");
   chk_pc_locked: assert property (reg_wr && reg_addr == 8'h09 && engine_execute[0]
      && !engine_instr_done[0] |=> $stable(engine_pc[3:0]))
      else $error("Counter written while active");
   cov_advance: cover property (engine_pc_advance[0]);
   cov_run: cover property (reg_wr && reg_addr == 8'h00 && reg_wdata[5:4] == 2'h2);
   cov_locked: cover property (reg_wr && reg_addr == 8'h09 && engine_execute[0]);
endmodule // lps_led_pwm_props
bind lps_led_pwm lps_led_pwm_props #(.NUM_ENG(NUM_ENG), .NUM_LED(NUM_LED)) i_props (
   .sys_clk(sys_clk), .arst_n(arst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .engine_instr_done(engine_instr_done), .engine_execute(engine_execute),
   .engine_pc_advance(engine_pc_advance), .engine_pc(engine_pc),
   .engine_mode(engine_mode), .internal_clock_select(internal_clock_select),
   .led_current(led_current));
`default_nettype wire

/* File: verification/lps_exec_model.sv */
// Purpose: Instruction executor stand-in for one engine
// Assumes: Done pulse lat cycles after execution is requested
// Notes:   Silent while the engine is idle
`default_nettype none
module lps_exec_model (
   input  wire logic       sys_clk,
   input  wire logic       execute,
   input  wire logic [7:0] lat,
   output var  logic       done
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      done = 1'b0;
      forever begin
         @(posedge sys_clk);
         if (execute === 1'b1) begin
            repeat (lat) @(posedge sys_clk);
            done <= 1'b1;
            @(posedge sys_clk);
            done <= 1'b0;
         end
      end
   end
endmodule // lps_exec_model
`default_nettype wire

/* File: verification/tb_top.sv */
// Purpose: Self-checking bench for LED source select and engine state
// Assumes: PWM judged at duty 00 and FF only
// Notes:   Full PWM frames are too long to run, so rate is not timed
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        sys_clk     = 1'b0;
   logic        arst_n      = 1'b0;
   logic        reg_wr      = 1'b0;
   logic        reg_rd      = 1'b0;
   logic [7:0]  reg_addr    = 8'h00;
   logic [7:0]  reg_wdata   = 8'h00;
   logic [23:0] engine_duty = 24'h000000;
   wire  [7:0]  reg_rdata;
   wire  [2:0]  engine_instr_done;
   wire  [2:0]  engine_execute;
   wire  [11:0] engine_pc;
   wire  [3:0]  led_pwm;
   wire  [31:0] led_current;
   wire         chip_on;
   wire         internal_clock_select;
   int          miscompares = 0;
   int          tests_run   = 0;
   int          cyc         = 0;
   int          i, e, k, n;
   logic [7:0]  m, p, x;
   logic [3:0]  db;
   logic [2:0]  eb;
   logic [7:0]  rz [11] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h08, 8'h09, 8'h0A,
                           8'h0B, 8'h0E, 8'h70};
   logic [7:0]  rw [6]  = '{8'h02, 8'h03, 8'h04, 8'h0E, 8'h70, 8'h08};
   always #5 sys_clk = ~sys_clk;
   lps_led_pwm i_dut (
      .sys_clk(sys_clk), .arst_n(arst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .engine_duty(engine_duty), .engine_instr_done(engine_instr_done),
      .engine_execute(engine_execute), .engine_pc_advance(), .engine_pc(engine_pc),
      .engine_mode(), .internal_clock_select(internal_clock_select),
      .chip_on(chip_on), .led_current(led_current), .led_pwm(led_pwm));
   for (genvar g = 0; g < 3; g++) begin : g_exec
      lps_exec_model i_exec (.sys_clk(sys_clk), .execute(engine_execute[g]),
         .lat(g == 1 ? 8'h14 : 8'h03), .done(engine_instr_done[g]));
   end
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic stop_test;
      $display("checks=%0d mismatches=%0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      @(negedge sys_clk);
      chk(reg_rdata, exp);
   endtask
   task automatic idle(input int en);
      @(negedge sys_clk);
      for (int j = 0; j < 400 && engine_execute[en] !== 1'b0; j++) @(negedge sys_clk);
   endtask
   function automatic logic [3:0] exp_led(logic [7:0] mp, logic [3:0] dir, logic [2:0] en);
      logic [3:0] r;
      for (int l = 0; l < 4; l++)
         r[l] = (mp[2*l+:2] == 2'h0) ? dir[l] : en[mp[2*l+:2] - 2'h1];
      return r;
   endfunction
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         miscompares++;
         stop_test;
      end
   end
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      void'($urandom(32'hd4f0));
      repeat (3) @(posedge sys_clk);
      arst_n <= 1'b1;
      for (i = 0; i < 11; i++) rd(rz[i], 8'h00);
      chk(led_current, 32'hAFAFAFAF);
      $display("test reset done");
      wr(8'h00, 8'h40);
      @(negedge sys_clk);
      chk(chip_on, 1'b1);
      for (i = 0; i < 6; i++) begin
         x = 8'($urandom);
         wr(rw[i], x);
         rd(rw[i], x);
      end
      chk(internal_clock_select, x[0]);
      wr(8'h7F, 8'hFF);
      rd(8'h7F, 8'h00);
      $display("test registers done");
      wr(8'h01, 8'h2A);
      for (i = 0; i < 5; i++) begin
         m  = (i == 0) ? 8'hE4 : 8'($urandom);
         db = 4'($urandom);
         eb = 3'($urandom);
         x  = {1'($urandom), 7'h40};
         wr(8'h70, m);
         engine_duty <= {{8{eb[2]}}, {8{eb[1]}}, {8{eb[0]}}};
         wr(8'h00, x);
         for (k = 0; k < 4; k++) wr(rw[k], {8{db[k]}});
         repeat (1600) @(posedge sys_clk);
         @(negedge sys_clk);
         chk(led_pwm, exp_led(m, db, eb));
      end
      $display("test routing done");
      m  = 8'hE4;
      db = 4'h5;
      wr(8'h70, m);
      for (k = 0; k < 4; k++) wr(rw[k], {8{db[k]}});
      wr(8'h01, 8'h00);
      repeat (2) @(negedge sys_clk);
      chk(led_pwm, exp_led(m, db, 3'h0));
      wr(8'h01, 8'h3F);
      repeat (2) @(negedge sys_clk);
      chk(led_pwm, exp_led(m, db, db[2:0]));
      wr(8'h01, 8'h2A);
      $display("test direct mode done");
      for (e = 0; e < 3; e++) begin
         p = 8'($urandom) & 8'h0F;
         wr(8'h09 + e[7:0], p);
         rd(8'h09 + e[7:0], p);
         wr(8'h00, 8'h40 | (8'h01 << (4 - 2 * e)));
         idle(e);
         rd(8'h09 + e[7:0], (p + 8'h01) & 8'h0F);
         rd(8'h00, 8'h40);
         wr(8'h00, 8'h40 | (8'h03 << (4 - 2 * e)));
         idle(e);
         rd(8'h09 + e[7:0], (p + 8'h01) & 8'h0F);
         rd(8'h00, 8'h40);
         wr(8'h00, 8'h40 | (8'h02 << (4 - 2 * e)));
         wr(8'h09 + e[7:0], 8'h00);
         k = 0;
         for (n = 0; n < 400 && k < 3; n++) begin
            @(posedge sys_clk);
            if (engine_instr_done[e] === 1'b1) k++;
         end
         @(negedge sys_clk);
         chk(engine_pc[4*e+:4], (p + 8'h04) & 8'h0F);
         chk(engine_execute[e], 1'b1);
         wr(8'h00, 8'h40);
         idle(e);
         chk(engine_execute[e], 1'b0);
      end
      $display("test engines done");
      arst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      arst_n <= 1'b1;
      for (i = 0; i < 11; i++) rd(rz[i], 8'h00);
      chk(led_pwm, 4'h0);
      $display("test second reset done");
      stop_test;
   end
endmodule // tb_top
`default_nettype wire
